/* inc/brm_map.svh */
`ifndef BRM_MAP_SVH
`define BRM_MAP_SVH

// Operating mode encodings
`define BRM_MODE_USR      5'h10
`define BRM_MODE_FIQ      5'h11
`define BRM_MODE_IRQ      5'h12
`define BRM_MODE_SVC      5'h13
`define BRM_MODE_ABT      5'h17
`define BRM_MODE_UND      5'h1B
`define BRM_MODE_SYS      5'h1F

// Status word layout
`define BRM_SR_MODE_HI    4
`define BRM_SR_T          5
`define BRM_SR_F          6
`define BRM_SR_I          7
`define BRM_SR_J          24
`define BRM_SR_RESET      32'h000000D3

// Physical register file slots
`define BRM_NUM_PHYS      31
`define BRM_PH_R8_FIQ     5'h0D
`define BRM_PH_BANK_USR   5'h12
`define BRM_PH_BANK_SVC   5'h14
`define BRM_PH_BANK_ABT   5'h16
`define BRM_PH_BANK_UND   5'h18
`define BRM_PH_BANK_IRQ   5'h1A
`define BRM_PH_BANK_FIQ   5'h1C
`define BRM_PH_PC         5'h1E

// Saved status slots
`define BRM_NUM_SAVED     5
`define BRM_SV_SVC        3'h0
`define BRM_SV_ABT        3'h1
`define BRM_SV_UND        3'h2
`define BRM_SV_IRQ        3'h3
`define BRM_SV_FIQ        3'h4

// Architectural register numbers
`define BRM_REG_R8        4'h8
`define BRM_REG_SP        4'hD
`define BRM_REG_LR        4'hE
`define BRM_REG_PC        4'hF

// Access sizes
`define BRM_SZ_BYTE       2'h0
`define BRM_SZ_HALF       2'h1
`define BRM_SZ_WORD       2'h2

// Bytecodes at or above this value run as native sequences
`define BRM_BC_EXPAND_MIN 8'hC0

// Pipeline stage slots
`define BRM_PIPE_STAGES   6
`define BRM_STG_ENTRY_BC  0
`define BRM_STG_ENTRY_NAT 1
`define BRM_STG_EXE       3

`endif

/* inc/brm_pkg.sv */
package brm_pkg;

   typedef enum logic [2:0] {
      brm_is_word = 3'b001,
      brm_is_half = 3'b010,
      brm_is_byte = 3'b100
   } brm_istate_t;

   typedef enum logic [2:0] {
      brm_k_plain                    = 3'h0,
      brm_k_branch_exchange          = 3'h1,
      brm_k_branch_link_exchange     = 3'h2,
      brm_k_load_pc                  = 3'h3,
      brm_k_branch_exchange_bytecode = 3'h4,
      brm_k_return                   = 3'h5,
      brm_k_mode_write               = 3'h6
   } brm_kind_t;

endpackage : brm_pkg

/* inc/brm_pipe_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface brm_pipe_if;
   logic        issue;
   logic        bytecode;
   logic [3:0]  dst;
   logic [3:0]  src_a;
   logic [3:0]  src_b;
   logic        flush;
   logic [31:0] res_data;
   logic        hazard;
   logic        fwd_a;
   logic        fwd_b;
   logic [31:0] fwd_a_data;
   logic [31:0] fwd_b_data;
   logic        wb_valid;
   logic [3:0]  wb_dst;
   logic [31:0] wb_data;

   modport ctl (output issue, bytecode, dst, src_a, src_b, flush, res_data,
                input  hazard, fwd_a, fwd_b, fwd_a_data, fwd_b_data, wb_valid, wb_dst, wb_data);
   modport pipe (input  issue, bytecode, dst, src_a, src_b, flush, res_data,
                 output hazard, fwd_a, fwd_b, fwd_a_data, fwd_b_data, wb_valid, wb_dst, wb_data);
endinterface : brm_pipe_if
`default_nettype wire

/* hdl/brm_pipe.sv */
`timescale 1ns/100ps
`default_nettype none
`include "brm_map.svh"
module brm_pipe #(
   parameter int STAGES = `BRM_PIPE_STAGES
) (
   input wire logic  core_clk,
   input wire logic  resetn,
   brm_pipe_if.pipe  pif
);
   generate
      if (STAGES != `BRM_PIPE_STAGES) begin : g_chk
         $error("brm_pipe: stage count fixed by state depths");
      end
   endgenerate

   logic [STAGES-1:0] vld_r;
   logic [STAGES-1:0] vld_nxt;
   logic [STAGES-1:0] has_r;
   logic [STAGES-1:0] has_nxt;
   logic [3:0]        dst_r   [STAGES];
   logic [3:0]        dst_nxt [STAGES];
   logic [31:0]       dat_r   [STAGES];
   logic [31:0]       dat_nxt [STAGES];

   // Only instructions that write a register are tracked
   always_comb begin
      vld_nxt = '0;
      has_nxt = '0;
      for (int s = 0; s < STAGES; s++) begin
         dst_nxt[s] = 4'h0;
         dat_nxt[s] = 32'h00000000;
      end
      for (int s = 1; s < STAGES; s++) begin
         vld_nxt[s] = vld_r[s-1];
         has_nxt[s] = has_r[s-1];
         dst_nxt[s] = dst_r[s-1];
         dat_nxt[s] = dat_r[s-1];
      end
      // Result is taken as the entry leaves execute
      if (vld_r[`BRM_STG_EXE]) begin
         has_nxt[`BRM_STG_EXE+1] = 1'b1;
         dat_nxt[`BRM_STG_EXE+1] = pif.res_data;
      end
      if (pif.flush) begin
         for (int s = 0; s <= `BRM_STG_EXE; s++) begin
            vld_nxt[s] = 1'b0;
         end
      end
      // Bytecode enters one slot earlier: two decode cycles
      if (pif.issue) begin
         if (pif.bytecode) begin
            vld_nxt[`BRM_STG_ENTRY_BC] = 1'b1;
            dst_nxt[`BRM_STG_ENTRY_BC] = pif.dst;
         end else begin
            vld_nxt[`BRM_STG_ENTRY_NAT] = 1'b1;
            dst_nxt[`BRM_STG_ENTRY_NAT] = pif.dst;
         end
      end
   end

   // Stall on a producer not yet past execute, else forward youngest
   always_comb begin
      pif.hazard     = 1'b0;
      pif.fwd_a      = 1'b0;
      pif.fwd_b      = 1'b0;
      pif.fwd_a_data = 32'h00000000;
      pif.fwd_b_data = 32'h00000000;
      for (int s = 0; s <= `BRM_STG_EXE; s++) begin
         if (vld_r[s] && (dst_r[s] == pif.src_a || dst_r[s] == pif.src_b)) begin
            pif.hazard = 1'b1;
         end
      end
      for (int s = STAGES - 1; s > `BRM_STG_EXE; s--) begin
         if (vld_r[s] && has_r[s] && dst_r[s] == pif.src_a) begin
            pif.fwd_a      = 1'b1;
            pif.fwd_a_data = dat_r[s];
         end
         if (vld_r[s] && has_r[s] && dst_r[s] == pif.src_b) begin
            pif.fwd_b      = 1'b1;
            pif.fwd_b_data = dat_r[s];
         end
      end
   end

   assign pif.wb_valid = vld_r[STAGES-1];
   assign pif.wb_dst   = dst_r[STAGES-1];
   assign pif.wb_data  = dat_r[STAGES-1];

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         vld_r <= '0;
         has_r <= '0;
         for (int s = 0; s < STAGES; s++) begin
            dst_r[s] <= 4'h0;
            dat_r[s] <= 32'h00000000;
         end
      end else begin
         vld_r <= vld_nxt;
         has_r <= has_nxt;
         dst_r <= dst_nxt;
         dat_r <= dat_nxt;
      end
   end
endmodule : brm_pipe
`default_nettype wire

/* hdl/brm_core_state.sv */
// Contract
// - Three states: word, halfword, bytecode instructions.
// - Bytecode state fetches always whole words.
// - Branch exchanges or pc loads toggle word/half.
// - Word/bytecode switch only by bytecode branch; exception entry and return also switch it here.
// - Exceptions run word state; return restores state.
// - Word and half states: five-stage pipeline.
// - Bytecode state: six stages, two decode.
// - Word, half aligned; bytes anywhere.
// - Detect register hazards; stall or forward.
// - Common bytecodes direct; rare ones expanded.
// - Interrupt in bytecode forces word state, restartable.
// - Seven modes; all but user privileged.
// - Aborts enter abort; undefined enters undefined.
// - Mode changes by software or exceptions.
// - 31 general plus six status registers.
// - Per-mode banking of r13/r14, fiq r8-r14.
// - Status word holds five-bit mode field.
// - Bytecode bit set means bytecode state.
// - Exception entry saves status into target slot.
`timescale 1ns/100ps
`default_nettype none
`include "brm_map.svh"
module brm_core_state #(
   parameter int DATA_W = 32
) (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        iss_valid,
   input  wire logic [2:0]  iss_kind,
   input  wire logic [3:0]  iss_src_a,
   input  wire logic [3:0]  iss_src_b,
   input  wire logic [3:0]  iss_dst,
   input  wire logic        iss_dst_en,
   input  wire logic        iss_tgt_lsb,
   input  wire logic [4:0]  iss_mode,
   input  wire logic [31:0] iss_link,
   input  wire logic [31:0] res_data,
   input  wire logic        exc_dabort,
   input  wire logic        exc_pabort,
   input  wire logic        exc_undef,
   input  wire logic        exc_swi,
   input  wire logic        fiq_pin,
   input  wire logic        irq_pin,
   input  wire logic [31:0] exc_link,
   input  wire logic        dacc_valid,
   input  wire logic [1:0]  dacc_size,
   input  wire logic [1:0]  dacc_addr_lo,
   input  wire logic [31:0] fetch_pc,
   input  wire logic        bc_valid,
   input  wire logic [7:0]  bc_opcode,
   output logic             iss_done_r,
   output logic             iss_stall_r,
   output logic [31:0]      rd_a_data_r,
   output logic [31:0]      rd_b_data_r,
   output logic [31:0]      current_status_word_r,
   output logic [2:0]       istate_r,
   output logic             privileged_r,
   output logic             exc_taken_r,
   output logic [4:0]       exc_mode_r,
   output logic             dacc_fault_r,
   output logic [31:0]      ifetch_addr_r,
   output logic [1:0]       ifetch_size_r,
   output logic             bc_native_r,
   output logic             bc_expand_r
);
   generate
      if (DATA_W != 32) begin : g_chk
         $error("brm_core_state: only 32-bit data is served");
      end
   endgenerate

   // Six status words: one current plus five saved
   logic [31:0] cur_nxt;
   logic [31:0] saved_status_word_r   [`BRM_NUM_SAVED];
   logic [31:0] saved_status_word_nxt [`BRM_NUM_SAVED];
   // 31 physical general registers, program counter included
   logic [31:0] regs_r   [`BRM_NUM_PHYS];
   logic [31:0] regs_nxt [`BRM_NUM_PHYS];
   logic        fiq_s1_r, fiq_s1_nxt, fiq_s2_r, fiq_s2_nxt;
   logic        irq_s1_r, irq_s1_nxt, irq_s2_r, irq_s2_nxt;
   logic        iss_done_nxt, iss_stall_nxt, privileged_nxt, exc_taken_nxt;
   logic        dacc_fault_nxt, bc_native_nxt, bc_expand_nxt;
   logic [31:0] rd_a_nxt, rd_b_nxt, ifetch_addr_nxt;
   logic [2:0]  istate_nxt;
   logic [4:0]  exc_mode_nxt;
   logic [1:0]  ifetch_size_nxt;

   brm_pipe_if pif ();

   brm_pipe #(
      .STAGES (`BRM_PIPE_STAGES)
   ) u_pipe (
      .core_clk (core_clk),
      .resetn   (resetn),
      .pif      (pif)
   );

   // Banked slot for a register number in a mode
   function automatic logic [4:0] phys_idx(input logic [3:0] r, input logic [4:0] m);
      logic [4:0] base;
      base = `BRM_PH_BANK_USR;
      case (m)
         `BRM_MODE_SVC: base = `BRM_PH_BANK_SVC;
         `BRM_MODE_ABT: base = `BRM_PH_BANK_ABT;
         `BRM_MODE_UND: base = `BRM_PH_BANK_UND;
         `BRM_MODE_IRQ: base = `BRM_PH_BANK_IRQ;
         `BRM_MODE_FIQ: base = `BRM_PH_BANK_FIQ;
         default:       base = `BRM_PH_BANK_USR;
      endcase
      if (r == `BRM_REG_PC) begin
         return `BRM_PH_PC;
      end else if (r < `BRM_REG_R8) begin
         return {1'b0, r};
      end else if (r < `BRM_REG_SP) begin
         if (m == `BRM_MODE_FIQ) begin
            return 5'(`BRM_PH_R8_FIQ + {1'b0, r} - {1'b0, `BRM_REG_R8});
         end
         return {1'b0, r};
      end
      return 5'(base + {4'h0, (r == `BRM_REG_LR)});
   endfunction : phys_idx

   // User and system own no saved slot; callers check mode first
   function automatic logic [2:0] saved_idx(input logic [4:0] m);
      case (m)
         `BRM_MODE_ABT: return `BRM_SV_ABT;
         `BRM_MODE_UND: return `BRM_SV_UND;
         `BRM_MODE_IRQ: return `BRM_SV_IRQ;
         `BRM_MODE_FIQ: return `BRM_SV_FIQ;
         default:       return `BRM_SV_SVC;
      endcase
   endfunction : saved_idx

   function automatic logic mode_known(input logic [4:0] m);
      case (m)
         `BRM_MODE_USR, `BRM_MODE_FIQ, `BRM_MODE_IRQ, `BRM_MODE_SVC,
         `BRM_MODE_ABT, `BRM_MODE_UND, `BRM_MODE_SYS: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : mode_known

   // Bytecode bit wins; otherwise the halfword bit picks
   function automatic brm_pkg::brm_istate_t state_of(input logic [31:0] sr);
      if (sr[`BRM_SR_J]) begin
         return brm_pkg::brm_is_byte;
      end else if (sr[`BRM_SR_T]) begin
         return brm_pkg::brm_is_half;
      end
      return brm_pkg::brm_is_word;
   endfunction : state_of

   always_comb begin
      logic [4:0]              mode;
      logic [4:0]              new_mode;
      logic                    exc_any;
      logic                    dfault;
      logic                    accept;
      logic                    flush;
      brm_pkg::brm_istate_t    st;
      brm_pkg::brm_kind_t      kind;
      mode     = current_status_word_r[`BRM_SR_MODE_HI:0];
      st       = state_of(current_status_word_r);
      kind     = brm_pkg::brm_kind_t'(iss_kind);
      // Word on four, half on two, byte anywhere
      dfault = dacc_valid &&
               ((dacc_size == `BRM_SZ_WORD && dacc_addr_lo != 2'h0) ||
                (dacc_size == `BRM_SZ_HALF && dacc_addr_lo[0]));
      new_mode = `BRM_MODE_SVC;
      exc_any  = 1'b0;
      accept   = 1'b0;
      flush    = 1'b0;
      cur_nxt  = current_status_word_r;
      saved_status_word_nxt = saved_status_word_r;
      regs_nxt = regs_r;
      fiq_s1_nxt = fiq_pin;
      fiq_s2_nxt = fiq_s1_r;
      irq_s1_nxt = irq_pin;
      irq_s2_nxt = irq_s1_r;
      rd_a_nxt   = rd_a_data_r;
      rd_b_nxt   = rd_b_data_r;
      exc_mode_nxt = exc_mode_r;

      // Data abort outranks fast interrupt so a bus error is never lost
      if (exc_dabort || dfault) begin
         exc_any  = 1'b1;
         new_mode = `BRM_MODE_ABT;
      end else if (fiq_s2_r && !current_status_word_r[`BRM_SR_F]) begin
         exc_any  = 1'b1;
         new_mode = `BRM_MODE_FIQ;
      end else if (irq_s2_r && !current_status_word_r[`BRM_SR_I]) begin
         exc_any  = 1'b1;
         new_mode = `BRM_MODE_IRQ;
      end else if (exc_pabort) begin
         exc_any  = 1'b1;
         new_mode = `BRM_MODE_ABT;
      end else if (exc_undef) begin
         exc_any  = 1'b1;
         new_mode = `BRM_MODE_UND;
      end else if (exc_swi) begin
         exc_any  = 1'b1;
         new_mode = `BRM_MODE_SVC;
      end

      // Retire first so a same-cycle link write below takes precedence
      if (pif.wb_valid) begin
         regs_nxt[phys_idx(pif.wb_dst, mode)] = pif.wb_data;
      end

      if (exc_any) begin
         saved_status_word_nxt[saved_idx(new_mode)] = current_status_word_r;
         cur_nxt[`BRM_SR_MODE_HI:0] = new_mode;
         // Handler always in word state; interrupted bytecode reruns
         cur_nxt[`BRM_SR_T] = 1'b0;
         cur_nxt[`BRM_SR_J] = 1'b0;
         cur_nxt[`BRM_SR_I] = 1'b1;
         if (new_mode == `BRM_MODE_FIQ) begin
            cur_nxt[`BRM_SR_F] = 1'b1;
         end
         regs_nxt[phys_idx(`BRM_REG_LR, new_mode)] = exc_link;
         exc_mode_nxt = new_mode;
         flush = 1'b1;
      end else if (iss_valid && !pif.hazard) begin
         accept = 1'b1;
         rd_a_nxt = pif.fwd_a ? pif.fwd_a_data : regs_r[phys_idx(iss_src_a, mode)];
         rd_b_nxt = pif.fwd_b ? pif.fwd_b_data : regs_r[phys_idx(iss_src_b, mode)];
         case (kind)
            brm_pkg::brm_k_branch_exchange, brm_pkg::brm_k_load_pc: begin
               if (st != brm_pkg::brm_is_byte) begin
                  cur_nxt[`BRM_SR_T] = iss_tgt_lsb;
               end
            end
            brm_pkg::brm_k_branch_link_exchange: begin
               if (st != brm_pkg::brm_is_byte) begin
                  cur_nxt[`BRM_SR_T] = iss_tgt_lsb;
               end
               regs_nxt[phys_idx(`BRM_REG_LR, mode)] = iss_link;
            end
            brm_pkg::brm_k_branch_exchange_bytecode: begin
               // Halfword state has no direct path to bytecode
               if (st == brm_pkg::brm_is_word) begin
                  cur_nxt[`BRM_SR_J] = 1'b1;
               end else if (st == brm_pkg::brm_is_byte) begin
                  cur_nxt[`BRM_SR_J] = 1'b0;
               end
            end
            brm_pkg::brm_k_return: begin
               if (mode != `BRM_MODE_USR && mode != `BRM_MODE_SYS) begin
                  cur_nxt = saved_status_word_r[saved_idx(mode)];
               end
            end
            brm_pkg::brm_k_mode_write: begin
               // User may not leave user mode
               if (mode != `BRM_MODE_USR && mode_known(iss_mode)) begin
                  cur_nxt[`BRM_SR_MODE_HI:0] = iss_mode;
               end
            end
            default: begin
            end
         endcase
         // Younger work fetched in the old state is discarded
         if (cur_nxt[`BRM_SR_J] != current_status_word_r[`BRM_SR_J] ||
             cur_nxt[`BRM_SR_T] != current_status_word_r[`BRM_SR_T]) begin
            flush = 1'b1;
         end
      end

      pif.issue    = accept && iss_dst_en && kind == brm_pkg::brm_k_plain;
      pif.bytecode = (st == brm_pkg::brm_is_byte);
      pif.dst      = iss_dst;
      pif.src_a    = iss_src_a;
      pif.src_b    = iss_src_b;
      pif.flush    = flush;
      pif.res_data = res_data;

      iss_done_nxt   = accept;
      iss_stall_nxt  = iss_valid && !accept;
      exc_taken_nxt  = exc_any;
      dacc_fault_nxt = dfault;
      istate_nxt     = state_of(cur_nxt);
      privileged_nxt = cur_nxt[`BRM_SR_MODE_HI:0] != `BRM_MODE_USR;

      // Byte-aligned code still fetched a word at a time
      if (st == brm_pkg::brm_is_half) begin
         ifetch_size_nxt = `BRM_SZ_HALF;
         ifetch_addr_nxt = {fetch_pc[31:1], 1'b0};
      end else begin
         ifetch_size_nxt = `BRM_SZ_WORD;
         ifetch_addr_nxt = {fetch_pc[31:2], 2'h0};
      end

      // Rare bytecodes go to a native sequence instead of direct decode
      bc_native_nxt = bc_valid && st == brm_pkg::brm_is_byte &&
                      bc_opcode < `BRM_BC_EXPAND_MIN;
      bc_expand_nxt = bc_valid && st == brm_pkg::brm_is_byte &&
                      bc_opcode >= `BRM_BC_EXPAND_MIN;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         current_status_word_r <= `BRM_SR_RESET;
         for (int i = 0; i < `BRM_NUM_SAVED; i++) begin
            saved_status_word_r[i] <= 32'h00000000;
         end
         for (int i = 0; i < `BRM_NUM_PHYS; i++) begin
            regs_r[i] <= 32'h00000000;
         end
         fiq_s1_r      <= 1'b0;
         fiq_s2_r      <= 1'b0;
         irq_s1_r      <= 1'b0;
         irq_s2_r      <= 1'b0;
         iss_done_r    <= 1'b0;
         iss_stall_r   <= 1'b0;
         rd_a_data_r   <= 32'h00000000;
         rd_b_data_r   <= 32'h00000000;
         istate_r      <= brm_pkg::brm_is_word;
         privileged_r  <= 1'b1;
         exc_taken_r   <= 1'b0;
         exc_mode_r    <= `BRM_MODE_SVC;
         dacc_fault_r  <= 1'b0;
         ifetch_addr_r <= 32'h00000000;
         ifetch_size_r <= `BRM_SZ_WORD;
         bc_native_r   <= 1'b0;
         bc_expand_r   <= 1'b0;
      end else begin
         current_status_word_r <= cur_nxt;
         saved_status_word_r   <= saved_status_word_nxt;
         regs_r        <= regs_nxt;
         fiq_s1_r      <= fiq_s1_nxt;
         fiq_s2_r      <= fiq_s2_nxt;
         irq_s1_r      <= irq_s1_nxt;
         irq_s2_r      <= irq_s2_nxt;
         iss_done_r    <= iss_done_nxt;
         iss_stall_r   <= iss_stall_nxt;
         rd_a_data_r   <= rd_a_nxt;
         rd_b_data_r   <= rd_b_nxt;
         istate_r      <= istate_nxt;
         privileged_r  <= privileged_nxt;
         exc_taken_r   <= exc_taken_nxt;
         exc_mode_r    <= exc_mode_nxt;
         dacc_fault_r  <= dacc_fault_nxt;
         ifetch_addr_r <= ifetch_addr_nxt;
         ifetch_size_r <= ifetch_size_nxt;
         bc_native_r   <= bc_native_nxt;
         bc_expand_r   <= bc_expand_nxt;
      end
   end
endmodule : brm_core_state
`default_nettype wire

/* verif/brm_core_state_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module brm_core_state_chk (
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic        iss_valid,
   input wire logic        exc_dabort,
   input wire logic        exc_undef,
   input wire logic        dacc_valid,
   input wire logic [1:0]  dacc_size,
   input wire logic [1:0]  dacc_addr_lo,
   input wire logic        bc_valid,
   input wire logic [7:0]  bc_opcode,
   input wire logic        iss_done_r,
   input wire logic        iss_stall_r,
   input wire logic [31:0] current_status_word_r,
   input wire logic [2:0]  istate_r,
   input wire logic        privileged_r,
   input wire logic        exc_taken_r,
   input wire logic [4:0]  exc_mode_r,
   input wire logic        dacc_fault_r,
   input wire logic [1:0]  ifetch_size_r,
   input wire logic        bc_native_r,
   input wire logic        bc_expand_r
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_reset_super:
   assert property ($rose(resetn) |-> current_status_word_r[4:0] == 5'h13 && istate_r == 3'h1)
      else $error("reset state wrong");
   a_undef_entry:
   assert property (exc_undef |=> exc_taken_r && istate_r == 3'h1 && current_status_word_r[7])
      else $error("exception entry wrong");
   a_dabort_mode:
   assert property (exc_dabort |=> exc_mode_r == 5'h17 && privileged_r)
      else $error("abort mode not entered");
   a_mode_field:
   assert property (exc_taken_r |-> current_status_word_r[4:0] == exc_mode_r)
      else $error("mode field differs");
   a_priv_flag:
   assert property (privileged_r == (current_status_word_r[4:0] != 5'h10))
      else $error("privilege flag wrong");
   a_state_bits:
   assert property (istate_r[2] == current_status_word_r[24]
      && istate_r[1] == (current_status_word_r[5] && !current_status_word_r[24]))
      else $error("state bits differ");
   a_bc_fetch:
   assert property (istate_r == 3'h4 |=> ifetch_size_r == 2'h2)
      else $error("bytecode fetch not word");
   a_misalign_abort:
   assert property (dacc_valid && dacc_size == 2'h2 && dacc_addr_lo != 2'h0
      |=> dacc_fault_r && exc_mode_r == 5'h17)
      else $error("misaligned word missed");
   a_one_answer:
   assert property (iss_valid |=> iss_done_r != iss_stall_r)
      else $error("request answer wrong");
   a_bc_split:
   assert property (bc_valid && istate_r == 3'h4
      |=> bc_expand_r == ($past(bc_opcode) >= 8'hC0) && bc_native_r != bc_expand_r)
      else $error("bytecode class wrong");
   c_exc: cover property (exc_taken_r);
   c_stall: cover property (iss_stall_r);
   c_expand: cover property (bc_expand_r);
endmodule : brm_core_state_chk
bind brm_core_state brm_core_state_chk i_chk (.*);
`default_nettype wire

/* verif/brm_bus_model.sv */
`timescale 1ns/100ps
`default_nettype none
module brm_bus_model #(
   parameter logic [31:0] RESULT = 32'h00005A5A
) (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   output logic [31:0]      fetch_pc,
   output logic [31:0]      res_data
);
   // Byte steps so every low-bit pattern reaches the fetch aligner
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fetch_pc <= 32'h00000000;
      end else begin
         fetch_pc <= fetch_pc + 32'h00000001;
      end
   end
   assign res_data = RESULT;
endmodule : brm_bus_model
`default_nettype wire

/* verif/banked_register_mode_state_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module banked_register_mode_state_tb_top;
   localparam logic [31:0] RES = 32'h00005A5A;
   logic core_clk, resetn, iss_valid, iss_dst_en, iss_tgt_lsb, dacc_valid, bc_valid;
   logic fiq_pin, irq_pin, iss_done_r, iss_stall_r, privileged_r, exc_taken_r;
   logic dacc_fault_r, bc_native_r, bc_expand_r;
   logic [2:0]  iss_kind, istate_r;
   logic [3:0]  iss_src_a, iss_dst, exv;
   logic [4:0]  iss_mode, exc_mode_r;
   logic [1:0]  dacc_size, dacc_addr_lo, ifetch_size_r;
   logic [7:0]  bc_opcode;
   logic [31:0] fetch_pc, res_data, rd_a_data_r, current_status_word_r, ifetch_addr_r;
   int          num_errors, check_count, n;
   brm_core_state i_dut (.*, .iss_src_b(4'h0), .iss_link(32'h00000000),
      .exc_dabort(exv[3]), .exc_pabort(exv[2]), .exc_undef(exv[1]), .exc_swi(exv[0]),
      .exc_link(32'h00001234), .rd_b_data_r());
   brm_bus_model #(.RESULT(RES)) i_bus (.core_clk(core_clk), .resetn(resetn),
      .fetch_pc(fetch_pc), .res_data(res_data));
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic iss(input logic [2:0] k, input logic t, input logic [4:0] m,
                      input logic [3:0] a, input logic d);
      @(posedge core_clk);
      iss_valid <= 1'b1;
      iss_kind <= k;
      iss_tgt_lsb <= t;
      iss_mode <= m;
      iss_src_a <= a;
      iss_dst <= 4'h3;
      iss_dst_en <= d;
      @(posedge core_clk);
      iss_valid <= 1'b0;
      #1;
   endtask : iss
   task automatic ex(input logic [3:0] v);
      @(posedge core_clk);
      exv <= v;
      @(posedge core_clk);
      exv <= 4'h0;
      #1;
   endtask : ex
   task automatic acc(input logic [1:0] s, input logic [1:0] a);
      @(posedge core_clk);
      dacc_valid <= 1'b1;
      dacc_size <= s;
      dacc_addr_lo <= a;
      @(posedge core_clk);
      dacc_valid <= 1'b0;
      #1;
   endtask : acc
   task automatic bc(input logic [7:0] op);
      @(posedge core_clk);
      bc_valid <= 1'b1;
      bc_opcode <= op;
      @(posedge core_clk);
      bc_valid <= 1'b0;
      #1;
      chk("expand", {31'h0, op >= 8'hC0}, bc_expand_r);
   endtask : bc
   task automatic t_reset();
      chk("status", 32'h000000D3, current_status_word_r);
      chk("istate", 32'h1, istate_r);
      chk("fetch size", 32'h2, ifetch_size_r);
   endtask : t_reset
   task automatic t_hazard();
      iss(3'h0, 1'b0, 5'h0, 4'h0, 1'b1);
      chk("done", 32'h1, iss_done_r);
      iss(3'h0, 1'b0, 5'h0, 4'h3, 1'b0);
      chk("stall", 32'h1, iss_stall_r);
      for (n = 0; n < 8 && iss_done_r !== 1'b1; n++) iss(3'h0, 1'b0, 5'h0, 4'h3, 1'b0);
      chk("retry", 32'h1, n < 8);
      chk("operand", RES, rd_a_data_r);
   endtask : t_hazard
   task automatic t_states();
      iss(3'h1, 1'b1, 5'h0, 4'h0, 1'b0);
      chk("half", 32'h2, istate_r);
      @(posedge core_clk);
      #1;
      chk("half fetch", 32'h2, {ifetch_size_r, ifetch_addr_r[0]});
      iss(3'h4, 1'b0, 5'h0, 4'h0, 1'b0);
      chk("no bytecode", 32'h2, istate_r);
      iss(3'h2, 1'b0, 5'h0, 4'h0, 1'b0);
      chk("word", 32'h1, istate_r);
      iss(3'h3, 1'b1, 5'h0, 4'h0, 1'b0);
      chk("load pc", 32'h2, istate_r);
      iss(3'h1, 1'b0, 5'h0, 4'h0, 1'b0);
      chk("back", 32'h1, istate_r);
   endtask : t_states
   task automatic t_bytecode();
      iss(3'h4, 1'b0, 5'h0, 4'h0, 1'b0);
      chk("bytecode", 32'h1, current_status_word_r[24]);
      bc(8'hBF);
      bc(8'hC0);
      chk("bc fetch", 32'h8, {ifetch_size_r, ifetch_addr_r[1:0]});
      @(posedge core_clk) irq_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      irq_pin <= 1'b0;
      #1;
      chk("masked irq", 32'h4, istate_r);
      ex(4'h2);
      chk("undef", 32'h1B3, {exc_mode_r, istate_r, exc_taken_r});
      iss(3'h5, 1'b0, 5'h0, 4'h0, 1'b0);
      chk("restore", 32'h4, istate_r);
      iss(3'h4, 1'b0, 5'h0, 4'h0, 1'b0);
      chk("leave", 32'h1, istate_r);
   endtask : t_bytecode
   task automatic t_modes();
      iss(3'h6, 1'b0, 5'h11, 4'h0, 1'b0);
      chk("fiq mode", 32'h11, current_status_word_r[4:0]);
      acc(2'h2, 2'h2);
      chk("fault", 32'h37, {dacc_fault_r, exc_mode_r});
      acc(2'h0, 2'h3);
      chk("byte ok", 32'h0, dacc_fault_r);
      ex(4'h4);
      chk("pabort", 32'h17, exc_mode_r);
      ex(4'h1);
      chk("swi", 32'h13, exc_mode_r);
      iss(3'h6, 1'b0, 5'h10, 4'h0, 1'b0);
      chk("user", 32'h0, privileged_r);
      iss(3'h6, 1'b0, 5'h13, 4'h0, 1'b0);
      chk("user locked", 32'h10, current_status_word_r[4:0]);
      ex(4'h8);
      chk("dabort", 32'h37, {privileged_r, exc_mode_r});
      iss(3'h5, 1'b0, 5'h0, 4'h0, 1'b0);
      chk("saved", 32'h10, current_status_word_r[4:0]);
   endtask : t_modes
   task automatic conclude();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : conclude
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   initial begin
      #1000000;
      num_errors++;
      conclude();
   end
   initial begin
      {resetn, iss_valid, iss_dst_en, iss_tgt_lsb, dacc_valid, bc_valid, fiq_pin} = '0;
      {irq_pin, iss_kind, iss_src_a, iss_dst, exv, iss_mode, dacc_size} = '0;
      {dacc_addr_lo, bc_opcode, num_errors, check_count} = '0;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      #1;
      t_reset();
      t_hazard();
      t_states();
      t_bytecode();
      t_modes();
      conclude();
   end
endmodule : banked_register_mode_state_tb_top
`default_nettype wire
